// [include/uar_consts.vh]
// Register indices, field positions, reset values and timing counts of the serial receiver
`ifndef UAR_CONSTS_VH
`define UAR_CONSTS_VH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define UAR_IDX_PERIPHERAL_FLAGS_1 8'h0c
`define UAR_IDX_RECEIVE_STATUS_CONTROL 8'h18
`define UAR_IDX_TRANSMIT_BUFFER 8'h19
`define UAR_IDX_RECEIVE_BUFFER 8'h1a
`define UAR_IDX_PERIPHERAL_ENABLES_1 8'h8c
`define UAR_IDX_TRANSMIT_STATUS_CONTROL 8'h98
`define UAR_IDX_BIT_RATE_DIVISOR 8'h99

// ****************************************
// Field positions
// ****************************************
`define UAR_BIT_RECEIVE_FLAG 5
`define UAR_BIT_RECEIVE_IRQ_ENABLE 5
`define UAR_BIT_SERIAL_PORT_ENABLE 7
`define UAR_BIT_RECEIVE_NINE_BIT_SELECT 6
`define UAR_BIT_SINGLE_RECEIVE_ENABLE 5
`define UAR_BIT_CONTINUOUS_RECEIVE_ENABLE 4
`define UAR_BIT_FRAMING_ERROR 2
`define UAR_BIT_OVERRUN_ERROR 1
`define UAR_BIT_RECEIVED_NINTH_BIT 0
`define UAR_BIT_CLOCK_SOURCE_SELECT 7
`define UAR_BIT_TRANSMIT_NINE_BIT_SELECT 6
`define UAR_BIT_TRANSMIT_ENABLE 5
`define UAR_BIT_SYNC_MODE_SELECT 4
`define UAR_BIT_HIGH_SPEED_SELECT 2
`define UAR_BIT_SHIFT_REGISTER_EMPTY 1
`define UAR_BIT_TRANSMIT_NINTH_BIT 0

// ****************************************
// Reset values
// ****************************************
`define UAR_RST_BYTE 8'h00
`define UAR_RST_TRANSMIT_STATUS_CONTROL 8'h02

// ****************************************
// Timing counts
// ****************************************
`define UAR_OVERSAMPLE_LAST 4'hf
`define UAR_VOTE_FIRST 4'h6
`define UAR_VOTE_SECOND 4'h7
`define UAR_VOTE_DECIDE 4'h8
`define UAR_LOW_SPEED_PRESCALE_LAST 2'h3
`define UAR_SYNC_CLOCK_HALF_LAST 3'h7
`define UAR_LAST_BIT_EIGHT 4'h7
`define UAR_LAST_BIT_NINE 4'h8

`endif

// [rtl/uar_vote3.v]
// Three-sample majority detector for the oversampled receive line
`timescale 1ns/10ps
`default_nettype none

module uar_vote3 (
    input wire pclk,
    input wire presetn,
    input wire take,
    input wire line,
    output wire vote
);

    reg sample_a;
    reg sample_b;

    // Keep the two earlier samples
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sample_a <= 1'b1;
            sample_b <= 1'b1;
        end
        else if (take)
        begin
            sample_b <= sample_a;
            sample_a <= line;
        end
    end

    // Two out of three with the current sample
    assign vote = (sample_a & sample_b) | (sample_a & line) | (sample_b & line);

endmodule

`default_nettype wire

// [rtl/uar_usart_rx.v]
// Asynchronous serial receiver with two-entry receive FIFO and APB register file
//
// Notes on behaviour
// - Incoming line is recovered by a front end running at sixteen times the bit rate.
// - The shift register moves once per bit, not once per oversample tick.
// - Asynchronous reception runs only while continuous receive enable is set.
// - After the stop bit is sampled the word moves into the FIFO if room exists.
// - A word entering the FIFO sets the receive flag; interrupt needs its enable.
// - Receive flag is read only and clears when the FIFO is read empty.
// - Receive buffer is a two-entry FIFO read out in arrival order.
// - Third stop bit with FIFO full sets overrun and drops the shifted word.
// - While overrun is set no word enters the FIFO.
// - Overrun clears only by clearing continuous receive enable; software then sets it again.
// - Framing error is recorded when the sampled stop bit is low.
// - Framing error and ninth bit travel with each word; a read shows the next.
// - Asynchronous port is active with mode select clear and port enable set.
// - Nine-bit select receives nine data bits; the ninth shows in status.
// - Unimplemented register bits read as zero.
// - Synchronous master mode is half duplex; receiving and driving data exclude each other.
// - Mode select chooses synchronous mode; port enable turns pins into clock and data.
// - Clock source select makes the device drive the serial clock as master.
// - Frame is start bit, eight or nine data bits LSB first, one stop bit.
// - Each bit is a majority vote of oversample edges seven, eight and nine.
`timescale 1ns/10ps
`default_nettype none
`include "uar_consts.vh"

module uar_usart_rx #(
    parameter ADDR_W = 12
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire serial_data_line_in,
    output wire serial_data_line_out,
    output wire serial_data_line_oe,
    output reg serial_clock_line_out,
    output wire serial_clock_line_oe,
    output wire receive_irq
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam RX_IDLE = 2'b00;
    localparam RX_START = 2'b01;
    localparam RX_DATA = 2'b10;
    localparam RX_STOP = 2'b11;

    reg serial_port_enable;
    reg receive_nine_bit_select;
    reg single_receive_enable;
    reg continuous_receive_enable;
    reg overrun_error;
    reg [7:0] peripheral_enables_1;
    reg clock_source_select;
    reg transmit_nine_bit_select;
    reg transmit_enable;
    reg sync_mode_select;
    reg high_speed_select;
    reg transmit_ninth_bit;
    reg [7:0] transmit_buffer;
    reg [7:0] bit_rate_divisor;

    reg rx_meta;
    reg rx_sync;
    reg rx_prev;
    reg [1:0] pre_cnt;
    reg [7:0] brg_cnt;
    reg tick16;
    reg [2:0] sclk_cnt;
    reg [1:0] rx_state;
    reg [3:0] os_cnt;
    reg [3:0] bit_cnt;
    reg [8:0] receive_shift_register;
    reg [9:0] fifo_mem [0:1];
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] fifo_cnt;
    reg pop_armed;
    reg [7:0] rdata;
    reg reg_hit;

    wire vote;
    wire rx_on;
    wire brg_run;
    wire sync_master;
    wire rx_fall;
    wire vote_take;
    wire vote_now;
    wire stop_done;
    wire fifo_full;
    wire fifo_empty;
    wire push;
    wire pop;
    wire receive_flag;
    wire [9:0] head;
    wire [9:0] entry;
    wire [3:0] last_bit;
    wire [7:0] reg_idx;
    wire addr_ok;
    wire apb_setup;
    wire apb_write;

    // ****************************************
    // Mode decode and pins
    // ****************************************
    assign rx_on = serial_port_enable & ~sync_mode_select & continuous_receive_enable;
    assign sync_master = serial_port_enable & sync_mode_select & clock_source_select;
    assign brg_run = serial_port_enable & (transmit_enable | continuous_receive_enable | single_receive_enable);

    // Master drives the clock pin in synchronous mode
    assign serial_clock_line_oe = sync_master;

    // Data pin is released while any receive enable is set
    assign serial_data_line_oe = serial_port_enable & sync_mode_select & transmit_enable
        & ~(continuous_receive_enable | single_receive_enable);
    assign serial_data_line_out = 1'b1;

    // Receive request output gated by its enable
    assign receive_irq = receive_flag & peripheral_enables_1[`UAR_BIT_RECEIVE_IRQ_ENABLE];

    // ****************************************
    // Line synchroniser
    // ****************************************
    // Two flops, then an edge history flop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end
        else
        begin
            rx_meta <= serial_data_line_in;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    assign rx_fall = rx_prev & ~rx_sync;

    // ****************************************
    // Oversample tick generator
    // ****************************************
    // Sixteen ticks per bit; low speed adds a divide by four
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_cnt <= 2'h0;
            brg_cnt <= 8'h00;
            tick16 <= 1'b0;
        end
        else if (!brg_run)
        begin
            pre_cnt <= 2'h0;
            brg_cnt <= 8'h00;
            tick16 <= 1'b0;
        end
        else
        begin
            tick16 <= 1'b0;
            if (high_speed_select || pre_cnt == `UAR_LOW_SPEED_PRESCALE_LAST)
            begin
                pre_cnt <= 2'h0;
                if (brg_cnt == bit_rate_divisor)
                begin
                    brg_cnt <= 8'h00;
                    tick16 <= 1'b1;
                end
                else
                    brg_cnt <= brg_cnt + 8'h01;
            end
            else
                pre_cnt <= pre_cnt + 2'h1;
        end
    end

    // Master clock toggles every eight ticks, one period per bit
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_cnt <= 3'h0;
            serial_clock_line_out <= 1'b1;
        end
        else if (!sync_master || !brg_run)
        begin
            sclk_cnt <= 3'h0;
            serial_clock_line_out <= 1'b1;
        end
        else if (tick16)
        begin
            sclk_cnt <= sclk_cnt + 3'h1;
            if (sclk_cnt == `UAR_SYNC_CLOCK_HALF_LAST)
                serial_clock_line_out <= ~serial_clock_line_out;
        end
    end

    // ****************************************
    // Bit recovery
    // ****************************************
    assign vote_take = tick16 & (os_cnt == `UAR_VOTE_FIRST || os_cnt == `UAR_VOTE_SECOND);
    assign vote_now = tick16 & (os_cnt == `UAR_VOTE_DECIDE);

    uar_vote3 u_vote (
        .pclk(pclk),
        .presetn(presetn),
        .take(vote_take),
        .line(rx_sync),
        .vote(vote)
    );

    assign last_bit = receive_nine_bit_select ? `UAR_LAST_BIT_NINE : `UAR_LAST_BIT_EIGHT;

    // Frame sequencer: start, data bits, stop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state <= RX_IDLE;
            os_cnt <= 4'h0;
            bit_cnt <= 4'h0;
            receive_shift_register <= 9'h000;
        end
        else if (!rx_on)
            rx_state <= RX_IDLE;
        else
        begin
            case (rx_state)
                RX_IDLE:
                begin
                    if (rx_fall)
                    begin
                        rx_state <= RX_START;
                        os_cnt <= 4'h0;
                    end
                end
                default:
                begin
                    if (tick16)
                        os_cnt <= os_cnt + 4'h1;
                    if (vote_now)
                    begin
                        case (rx_state)
                            RX_START:
                            begin
                                if (vote)
                                    rx_state <= RX_IDLE;
                                else
                                begin
                                    rx_state <= RX_DATA;
                                    bit_cnt <= 4'h0;
                                end
                            end
                            RX_DATA:
                            begin
                                // LSB first, one shift per bit
                                receive_shift_register <= {vote, receive_shift_register[8:1]};
                                bit_cnt <= bit_cnt + 4'h1;
                                if (bit_cnt == last_bit)
                                    rx_state <= RX_STOP;
                            end
                            default:
                                rx_state <= RX_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Receive FIFO
    // ****************************************
    assign stop_done = rx_on & (rx_state == RX_STOP) & vote_now;
    assign fifo_full = (fifo_cnt == 2'h2);
    assign fifo_empty = (fifo_cnt == 2'h0);
    assign push = stop_done & ~overrun_error & ~fifo_full;
    assign pop = psel & penable & pop_armed;
    assign receive_flag = ~fifo_empty;
    assign head = fifo_empty ? 10'h000 : fifo_mem[rd_ptr];

    // Entry is framing error, ninth bit, data byte
    assign entry = receive_nine_bit_select
        ? {~vote, receive_shift_register[8], receive_shift_register[7:0]}
        : {~vote, 1'b0, receive_shift_register[8:1]};

    // Two entries, written and read by index
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fifo_mem[0] <= 10'h000;
            fifo_mem[1] <= 10'h000;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fifo_cnt <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                fifo_mem[wr_ptr] <= entry;
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                fifo_cnt <= fifo_cnt + 2'h1;
            else if (pop && !push)
                fifo_cnt <= fifo_cnt - 2'h1;
        end
    end

    // Overrun: set on a full FIFO, cleared by dropping the receive enable
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            overrun_error <= 1'b0;
        else if (!continuous_receive_enable)
            overrun_error <= 1'b0;
        else if (stop_done && fifo_full)
            overrun_error <= 1'b1;
    end

    // ****************************************
    // APB slave
    // ****************************************
    assign reg_idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'b00) && ((paddr >> 10) == {ADDR_W{1'b0}});
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pwrite & reg_hit;
    assign pready = 1'b1;

    // Read mux and address decode
    always @*
    begin
        rdata = 8'h00;
        reg_hit = addr_ok;
        case (reg_idx)
            `UAR_IDX_PERIPHERAL_FLAGS_1:
                rdata = {2'b00, receive_flag, 5'b00000};
            `UAR_IDX_RECEIVE_STATUS_CONTROL:
                rdata = {serial_port_enable, receive_nine_bit_select, single_receive_enable,
                    continuous_receive_enable, 1'b0, head[9], overrun_error, head[8]};
            `UAR_IDX_TRANSMIT_BUFFER:
                rdata = transmit_buffer;
            `UAR_IDX_RECEIVE_BUFFER:
                rdata = head[7:0];
            `UAR_IDX_PERIPHERAL_ENABLES_1:
                rdata = peripheral_enables_1;
            `UAR_IDX_TRANSMIT_STATUS_CONTROL:
                rdata = {clock_source_select, transmit_nine_bit_select, transmit_enable,
                    sync_mode_select, 1'b0, high_speed_select, 1'b1, transmit_ninth_bit};
            `UAR_IDX_BIT_RATE_DIVISOR:
                rdata = bit_rate_divisor;
            default:
                reg_hit = 1'b0;
        endcase
    end

    // Answer captured in the setup cycle; data pops only if it was valid then
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pop_armed <= 1'b0;
        end
        else if (apb_setup)
        begin
            prdata <= pwrite ? 32'h00000000 : {24'h000000, rdata};
            pslverr <= ~reg_hit;
            pop_armed <= ~pwrite & reg_hit & ~fifo_empty
                & (reg_idx == `UAR_IDX_RECEIVE_BUFFER);
        end
        else if (!psel)
        begin
            pslverr <= 1'b0;
            pop_armed <= 1'b0;
        end
    end

    // Software-written control registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_port_enable <= 1'b0;
            receive_nine_bit_select <= 1'b0;
            single_receive_enable <= 1'b0;
            continuous_receive_enable <= 1'b0;
            peripheral_enables_1 <= `UAR_RST_BYTE;
            clock_source_select <= 1'b0;
            transmit_nine_bit_select <= 1'b0;
            transmit_enable <= 1'b0;
            sync_mode_select <= 1'b0;
            high_speed_select <= 1'b0;
            transmit_ninth_bit <= 1'b0;
            transmit_buffer <= `UAR_RST_BYTE;
            bit_rate_divisor <= `UAR_RST_BYTE;
        end
        else if (apb_write)
        begin
            case (reg_idx)
                `UAR_IDX_RECEIVE_STATUS_CONTROL:
                begin
                    serial_port_enable <= pwdata[`UAR_BIT_SERIAL_PORT_ENABLE];
                    receive_nine_bit_select <= pwdata[`UAR_BIT_RECEIVE_NINE_BIT_SELECT];
                    single_receive_enable <= pwdata[`UAR_BIT_SINGLE_RECEIVE_ENABLE];
                    continuous_receive_enable <= pwdata[`UAR_BIT_CONTINUOUS_RECEIVE_ENABLE];
                end
                `UAR_IDX_TRANSMIT_BUFFER:
                    transmit_buffer <= pwdata[7:0];
                `UAR_IDX_PERIPHERAL_ENABLES_1:
                    peripheral_enables_1 <= pwdata[7:0];
                `UAR_IDX_TRANSMIT_STATUS_CONTROL:
                begin
                    clock_source_select <= pwdata[`UAR_BIT_CLOCK_SOURCE_SELECT];
                    transmit_nine_bit_select <= pwdata[`UAR_BIT_TRANSMIT_NINE_BIT_SELECT];
                    transmit_enable <= pwdata[`UAR_BIT_TRANSMIT_ENABLE];
                    sync_mode_select <= pwdata[`UAR_BIT_SYNC_MODE_SELECT];
                    high_speed_select <= pwdata[`UAR_BIT_HIGH_SPEED_SELECT];
                    transmit_ninth_bit <= pwdata[`UAR_BIT_TRANSMIT_NINTH_BIT];
                end
                `UAR_IDX_BIT_RATE_DIVISOR:
                    bit_rate_divisor <= pwdata[7:0];
                default:
                    bit_rate_divisor <= bit_rate_divisor;
            endcase
        end
    end

endmodule

`default_nettype wire

// [testbench/uar_usart_rx_asserts.sv]
// Port-level assertions for the serial receiver
`timescale 1ns/10ps
`default_nettype none
`include "uar_consts.vh"

module uar_usart_rx_asserts #(
    parameter ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_data_line_in,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe,
    input wire logic serial_clock_line_out,
    input wire logic serial_clock_line_oe,
    input wire logic receive_irq
);
    // ********
    // Decode and shadows
    // ********
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic [7:0] idx = paddr[9:2];
    wire logic bad = paddr[1:0] != 2'h0 || paddr >= 1024 || !(idx inside {`UAR_IDX_PERIPHERAL_FLAGS_1,
        `UAR_IDX_RECEIVE_STATUS_CONTROL, `UAR_IDX_TRANSMIT_BUFFER, `UAR_IDX_RECEIVE_BUFFER,
        `UAR_IDX_PERIPHERAL_ENABLES_1, `UAR_IDX_TRANSMIT_STATUS_CONTROL, `UAR_IDX_BIT_RATE_DIVISOR});
    wire logic hit = psel && penable && !bad;
    wire logic pop_c = hit && !pwrite && idx == `UAR_IDX_RECEIVE_BUFFER;
    wire logic enw_c = hit && pwrite && idx == `UAR_IDX_PERIPHERAL_ENABLES_1;
    logic [7:0] tx_sh;
    logic ie_sh, rx_sh;

    // Shadows of written register bits
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {tx_sh, ie_sh, rx_sh} <= 10'h000;
        else if (hit && pwrite && idx == `UAR_IDX_TRANSMIT_BUFFER)
            tx_sh <= pwdata[7:0];
        else if (enw_c)
            ie_sh <= pwdata[5];
        else if (hit && pwrite && idx == `UAR_IDX_RECEIVE_STATUS_CONTROL)
            rx_sh <= |pwdata[5:4];
    end

    // ********
    // Properties
    // ********
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_quiet;
        !pop_c && !enw_c;
    endsequence
    property p_ready;
        pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_upper;
        s_setup |=> prdata[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_err;
        s_setup |=> pslverr == $past(bad);
    endproperty
    a_err: assert property (p_err) else $error("slave error wrong");
    property p_txback;
        s_setup ##0 (!pwrite && !bad && idx == `UAR_IDX_TRANSMIT_BUFFER) |=> prdata[7:0] == tx_sh;
    endproperty
    a_txback: assert property (p_txback) else $error("tx readback wrong");
    property p_irq_hold;
        receive_irq && !pop_c && !enw_c ##1 s_quiet |=> receive_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("flag lost without read");
    property p_irq_mask;
        !ie_sh ##1 !ie_sh |-> !receive_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt while disabled");
    property p_sck;
        !$stable(serial_clock_line_out) |-> serial_clock_line_oe || $past(serial_clock_line_oe)
            || $past(serial_clock_line_oe, 2);
    endproperty
    a_sck: assert property (p_sck) else $error("clock moves off master");
    property p_dout;
        !(serial_data_line_oe && rx_sh) && serial_data_line_out;
    endproperty
    a_dout: assert property (p_dout) else $error("data pin driven while receiving");
endmodule

bind uar_usart_rx uar_usart_rx_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .serial_data_line_in, .serial_data_line_out, .serial_data_line_oe, .serial_clock_line_out,
    .serial_clock_line_oe, .receive_irq
);
`default_nettype wire

// [testbench/uar_tx_peer.sv]
// Remote serial transmitter model driving the receive line
`timescale 1ns/10ps
`default_nettype none

module uar_tx_peer #(
    parameter int BIT = 16
) (
    input wire logic pclk,
    output var logic line
);
    // Idle line rests high on its pull-up
    initial line = 1'b1;

    // One frame: start, data LSB first, stop
    task automatic send(input logic [8:0] d, input logic nine, input logic stop);
        logic [10:0] f;
        int n;
        f = {1'b1, d, 1'b0};
        n = nine ? 11 : 10;
        f[n - 1] = stop;
        @(posedge pclk);
        for (int i = 0; i < n; i++)
        begin
            line <= f[i];
            repeat (BIT) @(posedge pclk);
        end
        line <= 1'b1;
    endtask
endmodule
`default_nettype wire

// [testbench/test_usart_async_receiver.sv]
// Self-checking bench for the serial receiver
`timescale 1ns/10ps
`default_nettype none
`include "uar_consts.vh"

`define CHK(g, e) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("unexpected at %0t got %0h expected %0h", $time, (g), (e)); \
        end \
    end

module test_usart_async_receiver;
    localparam logic [7:0] FLG = `UAR_IDX_PERIPHERAL_FLAGS_1,
        STA = `UAR_IDX_RECEIVE_STATUS_CONTROL,
        TXB = `UAR_IDX_TRANSMIT_BUFFER,
        RXB = `UAR_IDX_RECEIVE_BUFFER,
        ENA = `UAR_IDX_PERIPHERAL_ENABLES_1,
        TXS = `UAR_IDX_TRANSMIT_STATUS_CONTROL;
    logic pclk, presetn, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [7:0] w [4];
    logic [8:0] w9;
    int n_mismatch, samples_checked, cyc, n;
    wire logic rx, pready, pslverr, dout, doe, sck, soe, irq;
    wire logic [31:0] prdata;
    logic [7:0] adr [7] = '{FLG, STA, TXB, RXB, ENA, TXS, `UAR_IDX_BIT_RATE_DIVISOR};
    logic [7:0] rst [7] = '{5: 8'h02, default: 8'h00};

    uar_tx_peer u_peer (
        .pclk,
        .line(rx)
    );
    uar_usart_rx #(.ADDR_W(12)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .serial_data_line_in(rx), .serial_data_line_out(dout), .serial_data_line_oe(doe),
        .serial_clock_line_out(sck), .serial_clock_line_oe(soe), .receive_irq(irq)
    );

    // ********
    // Clock, limit, tasks
    // ********
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Cycle limit
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 12000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One APB transfer
    task automatic apb(input logic wr, input logic [7:0] i, d, input logic [1:0] lo = 2'h0);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, i, lo};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] i, e);
        apb(1'b0, i, 8'h00);
        `CHK(rd, {24'h0, e})
        `CHK(err, 1'b0)
    endtask

    task automatic send(input logic [8:0] d, input logic nine, input logic stop);
        u_peer.send(d, nine, stop);
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic endt(input int t);
        $display("test %0d done", t);
    endtask

    // ********
    // Main sequence
    // ********
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        void'($urandom(32'h3ec1));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++)
            rdchk(adr[i], rst[i]);
        apb(1'b0, 8'h13, 8'h00);
        `CHK({err, rd}, 33'h100000000);
        apb(1'b1, STA, 8'hf0, 2'h1);
        `CHK(err, 1'b1);
        rdchk(STA, 8'h00);
        apb(1'b1, FLG, 8'hbf);
        rdchk(FLG, 8'h00);
        w[0] = 8'($urandom);
        apb(1'b1, TXB, w[0]);
        rdchk(TXB, w[0]);
        apb(1'b1, TXS, 8'h0c);
        rdchk(TXS, 8'h06);
        apb(1'b1, ENA, 8'h20);
        rdchk(ENA, 8'h20);
        endt(1);
        // Two words in order through the FIFO
        for (int i = 0; i < 4; i++)
            w[i] = 8'($urandom);
        w[2] = 8'hff;
        apb(1'b1, STA, 8'h90);
        send({1'b0, w[0]}, 1'b0, 1'b1);
        `CHK(irq, 1'b1);
        send({1'b0, w[1]}, 1'b0, 1'b1);
        rdchk(FLG, 8'h20);
        rdchk(STA, 8'h90);
        rdchk(RXB, w[0]);
        rdchk(RXB, w[1]);
        rdchk(FLG, 8'h00);
        endt(2);
        // Overrun, blocked words, restart
        for (int i = 0; i < 3; i++)
            send({1'b0, w[i]}, 1'b0, 1'b1);
        rdchk(STA, 8'h92);
        send({1'b0, ~w[0]}, 1'b0, 1'b1);
        rdchk(RXB, w[0]);
        rdchk(RXB, w[1]);
        rdchk(FLG, 8'h00);
        apb(1'b1, STA, 8'h80);
        apb(1'b1, STA, 8'h90);
        rdchk(STA, 8'h90);
        send({1'b0, w[3]}, 1'b0, 1'b1);
        rdchk(RXB, w[3]);
        endt(3);
        // Nine-bit words and framing error
        w9 = 9'($urandom) | 9'h100;
        apb(1'b1, STA, 8'hd0);
        send(w9, 1'b1, 1'b1);
        send({1'b0, w[1]}, 1'b1, 1'b0);
        rdchk(STA, 8'hd1);
        rdchk(RXB, w9[7:0]);
        rdchk(STA, 8'hd4);
        rdchk(RXB, w[1]);
        endt(4);
        // Receiver off, port off, masked
        apb(1'b1, STA, 8'h80);
        send({1'b0, w[2]}, 1'b0, 1'b1);
        `CHK(irq, 1'b0);
        apb(1'b1, STA, 8'h10);
        send({1'b0, w[2]}, 1'b0, 1'b1);
        rdchk(FLG, 8'h00);
        apb(1'b1, ENA, 8'h00);
        apb(1'b1, STA, 8'h90);
        send({1'b0, w[3]}, 1'b0, 1'b1);
        `CHK(irq, 1'b0);
        rdchk(FLG, 8'h20);
        rdchk(RXB, w[3]);
        endt(5);
        // Synchronous master pin roles
        apb(1'b1, TXS, 8'h94);
        @(negedge pclk);
        `CHK(soe, 1'b1);
        `CHK(doe, 1'b0);
        send({1'b0, w[0]}, 1'b0, 1'b1);
        rdchk(FLG, 8'h00);
        apb(1'b1, STA, 8'h80);
        apb(1'b1, TXS, 8'hb4);
        n = 0;
        repeat (40)
        begin
            @(negedge pclk);
            n += int'(sck === 1'b0);
        end
        `CHK(doe, 1'b1);
        `CHK(n > 0, 1'b1);
        endt(6);
        conclude();
    end
endmodule
`default_nettype wire
